// File: kss_ctlr_model.sv
// Controller model: drives the serial link and reads key data off the open-drain line
`timescale 1ns/1ps
`default_nettype none

module kss_ctlr_model
  import kss_pkg::*;
(
  output logic link_clk,
  output logic link_ce,
  output logic link_di,
  input wire logic do_line
);
  logic [READ_BITS-1:0] last;
  logic unreliable;

  initial begin
    link_clk = 1'b0;
    link_ce = 1'b0;
    link_di = 1'b0;
    last = '0;
    unreliable = 1'b0;
  end

  // Address MSB first with enable low, then n clocks with enable high; clock idles low
  task automatic frame(input logic [7:0] addr, input int n);
    for (int k = 7; k >= 0; k--) begin
      link_di = addr[k];
      #32 link_clk = 1'b1;
      #32 link_clk = 1'b0;
    end
    link_ce = 1'b1;
    for (int k = 0; k < n; k++) begin
      link_di = ~link_di;
      #32 link_clk = 1'b1;
      #32 link_clk = 1'b0;
      if (k < READ_BITS) begin
        last[k] = do_line;
      end
    end
    link_ce = 1'b0;
    unreliable = $countones(last[KEYS-1:0]) >= 3;
  endtask
endmodule

`default_nettype wire

// File: kss_ctrl.sv
// Key matrix scanner, sleep mode and held device reset of a segment driver
// Behaviour
// R01 - Sleep acknowledge reads 1 in sleep mode, 0 in normal mode.
// R02 - Sleep acknowledge is captured at key detection and returned with key data.
// R03 - Mode written while key request is low is adopted.
// R04 - Either sleep control bit at 1 enters sleep mode.
// R05 - Sleep drives segments and commons low and stops oscillator until a press.
// R06 - Both sleep control bits at 0 return the device to normal mode.
// R07 - First four segment pins stay general outputs in sleep when port select asks.
// R08 - One matrix scan lasts 384 oscillator periods.
// R09 - Two agreeing scans give a press; request goes low 800 periods after start.
// R10 - Disagreeing scans with a key held restart a fresh pair of scans.
// R11 - Normal idle holds all drive lines high; scanning runs until all released.
// R12 - Several presses set several key bits at once.
// R13 - Key request line is released while chip enable is high.
// R14 - After the key data read, request releases and a new scan starts.
// R15 - Sleep drive lines follow sleep bits; only high lines wake and get pulses.
// R16 - A key read in sleep clears the request but keeps sleep mode.
// R17 - Controller ignores key words with three or more set bits.
// R18 - Reset held from power-up or supply drop until last transfer's CE fall.
// R19 - Base clock stops in reset; oscillator mode set once sleep bits arrive.
// R20 - Display outputs off during reset while the latch still takes data.
// R21 - Reset returns scanner to idle with scanning off and key buffer cleared.
// R22 - Serial interface and control register are not cleared by device reset.
// R23 - Key bit index is drive line times five plus return input.
// R24 - Controller sends read address 43H before clocking out key data.
// R25 - Key request line is open drain, pulled low only to request or send 0.
`timescale 1ns/1ps
`default_nettype none

module kss_ctrl
  import kss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic link_ce,
  input wire logic link_di,
  output logic link_do_out,
  output logic link_do_oe,
  input wire logic supply_drop_detector,
  input wire logic ctl_load,
  input wire kss_ctl_t ctl_in,
  input wire logic final_transfer,
  input wire logic [4:0] return_input_lines,
  output logic [5:0] scan_drive_lines,
  output logic rc_oscillator_pin,
  output logic seg_com_off,
  output logic [3:0] gpo_enable,
  output logic sleep_ack_bit,
  output logic dev_reset,
  output kss_key_word_t key_word
);

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic [5:0] line_mask(input kss_ctl_t c);
    unique case ({c.sleep_ctl_bit_a, c.sleep_ctl_bit_b})
      2'b00: line_mask = ALL_LINES;
      2'b01: line_mask = MASK_B_ONLY;
      2'b10: line_mask = MASK_A_ONLY;
      2'b11: line_mask = ALL_LINES;
    endcase
  endfunction

  function automatic logic [3:0] port_decode(input kss_ctl_t c);
    unique case ({c.port_select_bit_a, c.port_select_bit_b})
      2'b00: port_decode = GPO_NONE;
      2'b01: port_decode = GPO_B_ONLY;
      2'b10: port_decode = GPO_A_ONLY;
      2'b11: port_decode = GPO_ALL;
    endcase
  endfunction

  function automatic logic [2:0] slot_of(input logic [9:0] c);
    logic [9:0] t;
    t = (c >= 10'(SCAN_CYC)) ? c - 10'(SCAN_CYC) : c;
    slot_of = 3'(t / 10'(SLOT_CYC));
  endfunction

  kss_main_t s, n;
  kss_link_t lk, ln;
  logic sleep, read_ev, ce_fall, press, sample;
  logic [2:0] slot;
  logic [5:0] smask;

  // ****************************************
  // Reference clock domain
  // ****************************************
  always_comb begin
    n = s;
    sleep = 1'b0;
    read_ev = 1'b0;
    ce_fall = 1'b0;
    press = 1'b0;
    sample = 1'b0;
    slot = '0;
    smask = line_mask(s.ctl);
    // Pins pass three flops; a change counts once stages two and three agree
    n.ret_s1 = return_input_lines;
    n.ret_s2 = s.ret_s1;
    n.ret_s3 = s.ret_s2;
    if (s.ret_s2 == s.ret_s3) begin
      n.ret = s.ret_s3;
    end
    n.ce_s1 = link_ce;
    n.ce_s2 = s.ce_s1;
    n.ce_s3 = s.ce_s2;
    if (s.ce_s2 == s.ce_s3) begin
      n.ce = s.ce_s3;
    end
    n.ce_d = s.ce;
    n.drop_s1 = supply_drop_detector;
    n.drop_s2 = s.drop_s1;
    n.drop_s3 = s.drop_s2;
    if (s.drop_s2 == s.drop_s3) begin
      n.drop = s.drop_s3;
    end
    // Read completion arrives as a toggle from the link side
    n.dn_s1 = lk.done_tgl;
    n.dn_s2 = s.dn_s1;
    n.dn_s3 = s.dn_s2;
    read_ev = s.dn_s2 ^ s.dn_s3;
    ce_fall = s.ce_d & ~s.ce;

    // Held device reset
    if (s.drop) begin
      n.dev_rst = 1'b1; // R18
    end else if (ce_fall && final_transfer) begin
      n.dev_rst = 1'b0; // R18
    end

    // Control register keeps loading in any state, reset included
    if (ctl_load) begin
      n.ctl = ctl_in; // R03 R06 R22
    end
    sleep = s.ctl.sleep_ctl_bit_a | s.ctl.sleep_ctl_bit_b; // R04 R06
    press = |s.ret; // R15
    slot = slot_of(s.cnt);
    sample = (s.cnt < 10'(2 * SCAN_CYC)) &&
             ((s.cnt % 10'(SLOT_CYC)) == 10'(SLOT_CYC - 1));

    if (s.dev_rst) begin
      n.state = KSS_IDLE; // R21
      n.cnt = '0;
      n.scan_a = '0;
      n.scan_b = '0;
      n.kbuf = '0; // R21
      n.req = 1'b0;
    end else begin
      unique case (s.state)
        KSS_IDLE: begin
          if (press) begin
            n.state = KSS_SCAN; // R11 R15
            n.cnt = '0;
          end
        end
        KSS_SCAN: begin
          n.cnt = s.cnt + 10'd1;
          if (sample && smask[slot]) begin
            if (s.cnt < 10'(SCAN_CYC)) begin
              n.scan_a[int'(slot) * INPUTS +: INPUTS] = s.ret; // R12 R23
            end else begin
              n.scan_b[int'(slot) * INPUTS +: INPUTS] = s.ret; // R12 R23
            end
          end
          if (s.cnt == 10'(REQ_CYC - 1)) begin
            n.cnt = '0;
            n.scan_a = '0;
            n.scan_b = '0;
            if (s.scan_a == s.scan_b && |s.scan_a) begin
              n.state = KSS_REQ; // R09
              n.req = 1'b1;
              n.kbuf.key_bits = s.scan_a;
              n.kbuf.sleep_ack_bit = sleep; // R02
            end else if (press) begin
              n.state = KSS_SCAN; // R10
            end else begin
              n.state = KSS_IDLE; // R11
            end
          end
        end
        KSS_REQ: begin
          if (read_ev) begin
            n.req = 1'b0; // R14 R16
            n.state = KSS_SCAN; // R14
            n.cnt = '0;
          end
        end
      endcase
    end

    // Registered outputs derived from the next state
    n.do_low = n.req & ~n.ce; // R13 R25
    n.sa_now = n.ctl.sleep_ctl_bit_a | n.ctl.sleep_ctl_bit_b; // R01
    n.osc_run = ~n.dev_rst & (~n.sa_now | (n.state != KSS_IDLE)); // R05 R19
    n.seg_off = n.dev_rst | n.sa_now; // R05 R20
    n.gpo = n.dev_rst ? GPO_NONE : port_decode(n.ctl); // R07
    if (n.dev_rst) begin
      n.lines = RST_LINES;
    end else if (n.state == KSS_SCAN) begin
      if (n.cnt < 10'(2 * SCAN_CYC)) begin
        n.lines = (6'h01 << slot_of(n.cnt)) & line_mask(n.ctl); // R08 R15
      end else begin
        // Lines rise again after both scans so a held key is seen at the compare
        n.lines = line_mask(n.ctl); // R10 R15
      end
    end else begin
      n.lines = n.sa_now ? line_mask(n.ctl) : ALL_LINES; // R11 R15
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
      s.dev_rst <= 1'b1; // R18
      s.lines <= RST_LINES;
      s.seg_off <= 1'b1; // R20
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // Link clock domain
  // ****************************************
  always_comb begin
    ln = lk;
    ln.rst_s1 = reset;
    ln.rst_s2 = lk.rst_s1;
    ln.req_s1 = s.req;
    ln.req_s2 = lk.req_s1;
    ln.ce_d = link_ce;
    if (!link_ce) begin
      ln.addr = {lk.addr[6:0], link_di};
      ln.rd_active = 1'b0;
      ln.do_low = 1'b0;
    end else if (!lk.ce_d) begin
      // Key word is held still while the request stands
      if (lk.addr == KEY_READ_ADDR && lk.req_s2) begin
        ln.rd_active = 1'b1; // R24
        ln.sh = s.kbuf;
        ln.bcnt = '0;
        ln.do_low = ~s.kbuf[0]; // R25
      end
    end else if (lk.rd_active) begin
      ln.sh = lk.sh >> 1;
      ln.bcnt = lk.bcnt + 5'd1;
      ln.do_low = ~lk.sh[1]; // R25
      if (lk.bcnt == 5'(READ_BITS - 1)) begin
        ln.rd_active = 1'b0;
        ln.do_low = 1'b0;
        ln.done_tgl = ~lk.done_tgl; // R14
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lk.rst_s2) begin
      lk <= '0;
      lk.rst_s1 <= ln.rst_s1;
      lk.rst_s2 <= ln.rst_s2;
    end else begin
      lk <= ln;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Raw enable splits the pin: request only between frames, link data only inside one,
  // so the request drops at once when a frame starts and data ends though the clock stops
  assign link_do_out = 1'b0;
  assign link_do_oe = ~((s.do_low & ~link_ce) | (lk.do_low & link_ce)); // R13 R25
  assign scan_drive_lines = s.lines;
  assign rc_oscillator_pin = s.osc_run;
  assign seg_com_off = s.seg_off;
  assign gpo_enable = s.gpo;
  assign sleep_ack_bit = s.sa_now;
  assign dev_reset = s.dev_rst;
  assign key_word = s.kbuf;

  // ****************************************
  // Assertions
  // ****************************************
  property p_sleep_ack;
    @(posedge ref_clk) disable iff (reset)
    ctl_load |=> sleep_ack_bit == ($past(ctl_in.sleep_ctl_bit_a) | $past(ctl_in.sleep_ctl_bit_b));
  endproperty
  a_sleep_ack: assert property (p_sleep_ack) else $error("sleep ack mismatch"); // R01

  property p_sa_capture;
    @(posedge ref_clk) disable iff (reset)
    $rose(s.req) |-> key_word.sleep_ack_bit == $past(sleep_ack_bit);
  endproperty
  a_sa_capture: assert property (p_sa_capture) else $error("captured sleep ack wrong"); // R02

  property p_req_time;
    @(posedge ref_clk) disable iff (reset)
    $rose(s.req) |-> $past(s.state) == KSS_SCAN && $past(s.cnt) == 10'(REQ_CYC - 1);
  endproperty
  a_req_time: assert property (p_req_time) else $error("request not at scan end"); // R09

  property p_disagree_rescan;
    @(posedge ref_clk) disable iff (reset)
    (s.state == KSS_SCAN && s.cnt == 10'(REQ_CYC - 1) && s.scan_a != s.scan_b && press &&
     !s.dev_rst) |=> s.state == KSS_SCAN && s.cnt == 0;
  endproperty
  a_disagree_rescan: assert property (p_disagree_rescan) else $error("no rescan"); // R10

  property p_cnt_bound;
    @(posedge ref_clk) disable iff (reset)
    s.cnt <= 10'(REQ_CYC - 1);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("scan counter overran"); // R08

  property p_ce_release;
    @(posedge ref_clk) disable iff (reset)
    s.ce |-> !s.do_low;
  endproperty
  a_ce_release: assert property (p_ce_release) else $error("request driven during CE"); // R13

  property p_sleep_osc;
    @(posedge ref_clk) disable iff (reset)
    (s.state == KSS_IDLE && sleep_ack_bit) |-> !rc_oscillator_pin && seg_com_off;
  endproperty
  a_sleep_osc: assert property (p_sleep_osc) else $error("oscillator runs in sleep"); // R05

  property p_rst_clear;
    @(posedge ref_clk) disable iff (reset)
    s.dev_rst |=> key_word.key_bits == '0 && !s.req && s.state == KSS_IDLE;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("scanner not cleared in reset"); // R21

  property p_read_rescan;
    @(posedge ref_clk) disable iff (reset)
    (read_ev && s.state == KSS_REQ && !s.dev_rst) |=> s.state == KSS_SCAN && !s.req && s.cnt == 0;
  endproperty
  a_read_rescan: assert property (p_read_rescan) else $error("no rescan after read"); // R14

  property p_mask_lines;
    @(posedge ref_clk) disable iff (reset)
    (s.state == KSS_SCAN) |-> (scan_drive_lines & ~line_mask(s.ctl)) == '0;
  endproperty
  a_mask_lines: assert property (p_mask_lines) else $error("pulse on low line"); // R15

  property p_gpo;
    @(posedge ref_clk) disable iff (reset)
    gpo_enable == (s.dev_rst ? GPO_NONE : port_decode(s.ctl));
  endproperty
  a_gpo: assert property (p_gpo) else $error("port select not applied"); // R07

  property p_rst_release;
    @(posedge ref_clk) disable iff (reset)
    $fell(s.dev_rst) |-> $past(ce_fall) && $past(final_transfer);
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("reset released early"); // R18

  property p_link_drive;
    @(posedge link_clk) disable iff (lk.rst_s2)
    lk.do_low |-> lk.rd_active && link_ce;
  endproperty
  a_link_drive: assert property (p_link_drive) else $error("link drives outside read"); // R25

  c_req: cover property (@(posedge ref_clk) disable iff (reset) $rose(s.req));
  c_rescan: cover property (@(posedge ref_clk) disable iff (reset)
    s.state == KSS_SCAN && s.cnt == 10'(REQ_CYC - 1) ##1 s.state == KSS_SCAN);
  c_read: cover property (@(posedge ref_clk) disable iff (reset) read_ev && s.state == KSS_REQ);
  c_release: cover property (@(posedge ref_clk) disable iff (reset) $fell(s.dev_rst));
  c_wake: cover property (@(posedge ref_clk) disable iff (reset)
    sleep_ack_bit && $rose(rc_oscillator_pin));

endmodule

`default_nettype wire

// File: kss_pkg.sv
// Shared constants, types and state records of the key scan, sleep and reset controller
package kss_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int OSC_T_NS = 50;
  localparam int CLK_NS = 50;
  localparam int SCAN_T = 384;
  localparam int REQ_T = 800;
  localparam int SCAN_CYC = (SCAN_T * OSC_T_NS + CLK_NS - 1) / CLK_NS;
  localparam int REQ_CYC = (REQ_T * OSC_T_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // Matrix geometry and link
  // ****************************************
  localparam int LINES = 6;
  localparam int INPUTS = 5;
  localparam int KEYS = LINES * INPUTS;
  localparam int SLOT_CYC = SCAN_CYC / LINES;
  localparam int READ_BITS = KEYS + 1;
  localparam logic [7:0] KEY_READ_ADDR = 8'h43;
  localparam logic [5:0] ALL_LINES = 6'h3F;
  localparam logic [5:0] RST_LINES = 6'h20;
  localparam logic [5:0] MASK_B_ONLY = 6'h20;
  localparam logic [5:0] MASK_A_ONLY = 6'h30;
  localparam logic [3:0] GPO_NONE = 4'h0;
  localparam logic [3:0] GPO_B_ONLY = 4'h3;
  localparam logic [3:0] GPO_A_ONLY = 4'h7;
  localparam logic [3:0] GPO_ALL = 4'hF;

  typedef enum logic [1:0] {KSS_IDLE, KSS_SCAN, KSS_REQ} kss_state_t;

  typedef struct packed {
    logic sleep_ctl_bit_a;
    logic sleep_ctl_bit_b;
    logic port_select_bit_a;
    logic port_select_bit_b;
  } kss_ctl_t;

  typedef struct packed {
    logic sleep_ack_bit;
    logic [KEYS-1:0] key_bits;
  } kss_key_word_t;

  typedef struct packed {
    logic [4:0] ret_s1, ret_s2, ret_s3, ret;
    logic ce_s1, ce_s2, ce_s3, ce, ce_d;
    logic drop_s1, drop_s2, drop_s3, drop;
    logic dn_s1, dn_s2, dn_s3;
    logic dev_rst;
    kss_ctl_t ctl;
    kss_state_t state;
    logic [9:0] cnt;
    logic [KEYS-1:0] scan_a, scan_b;
    kss_key_word_t kbuf;
    logic req;
    logic do_low;
    logic [5:0] lines;
    logic osc_run;
    logic seg_off;
    logic [3:0] gpo;
    logic sa_now;
  } kss_main_t;

  typedef struct packed {
    logic rst_s1, rst_s2;
    logic req_s1, req_s2;
    logic ce_d;
    logic [7:0] addr;
    logic rd_active;
    logic [4:0] bcnt;
    logic [READ_BITS-1:0] sh;
    logic do_low;
    logic done_tgl;
  } kss_link_t;

endpackage

// File: tb_kss_ctrl.sv
// Self-checking bench of the key scan, sleep and reset controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, act) begin tests_run++; if ((act) !== (exp)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, exp, act); end end

module tb_kss_ctrl
  import kss_pkg::*;
;
  logic ref_clk, reset, link_clk, link_ce, link_di, link_do_out, link_do_oe, do_line;
  logic supply_drop_detector, ctl_load, final_transfer, sleep_ack_bit, dev_reset;
  logic rc_oscillator_pin, seg_com_off;
  kss_ctl_t ctl_in;
  logic [4:0] ret;
  logic [5:0] lines;
  logic [3:0] gpo;
  logic [KEYS-1:0] keys;
  kss_key_word_t key_word;
  int fail_count = 0;
  int tests_run = 0;
  int n;

  // ********************************
  // Harness
  // ********************************
  assign do_line = link_do_oe ? 1'b1 : link_do_out;

  // Ideal key matrix: a pressed key joins its drive line to its return input
  always_comb begin
    ret = '0;
    for (int k = 0; k < KEYS; k++) begin
      if (keys[k] && lines[k / INPUTS]) begin
        ret[k % INPUTS] = 1'b1;
      end
    end
  end

  kss_ctrl i_kss_ctrl (
    .ref_clk(ref_clk),
    .reset(reset),
    .link_clk(link_clk),
    .link_ce(link_ce),
    .link_di(link_di),
    .link_do_out(link_do_out),
    .link_do_oe(link_do_oe),
    .supply_drop_detector(supply_drop_detector),
    .ctl_load(ctl_load),
    .ctl_in(ctl_in),
    .final_transfer(final_transfer),
    .return_input_lines(ret),
    .scan_drive_lines(lines),
    .rc_oscillator_pin(rc_oscillator_pin),
    .seg_com_off(seg_com_off),
    .gpo_enable(gpo),
    .sleep_ack_bit(sleep_ack_bit),
    .dev_reset(dev_reset),
    .key_word(key_word)
  );

  kss_ctlr_model i_kss_ctlr_model (
    .link_clk(link_clk),
    .link_ce(link_ce),
    .link_di(link_di),
    .do_line(do_line)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  task automatic load(input logic [3:0] c);
    ctl_in <= kss_ctl_t'(c);
    ctl_load <= 1'b1;
    cyc(1);
    ctl_load <= 1'b0;
    cyc(2);
  endtask

  task automatic wait_req(input int maxc);
    n = 0;
    while (do_line !== 1'b0 && n < maxc) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic rd(input kss_key_word_t exp);
    // One clock past the last bit closes the read and clears the request
    i_kss_ctlr_model.frame(KEY_READ_ADDR, READ_BITS + 1);
    cyc(1);
    `CHK("link_word", exp, i_kss_ctlr_model.last)
    `CHK("key_word", exp, key_word)
  endtask

  // Last frame of the set with final_transfer high ends the held reset
  task automatic release_dev();
    final_transfer <= 1'b1;
    cyc(1);
    i_kss_ctlr_model.frame(8'h41, 16);
    cyc(10);
    final_transfer <= 1'b0;
    `CHK("reset_released", 1'b0, dev_reset)
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    keys <= KEYS'(1) << 25;
    cyc(900);
    `CHK("req_in_reset", 1'b1, do_line)
    `CHK("lines_in_reset", RST_LINES, lines)
    `CHK("seg_off_in_reset", 1'b1, seg_com_off)
    `CHK("osc_in_reset", 1'b0, rc_oscillator_pin)
    `CHK("kbuf_in_reset", 31'h0, key_word)
    keys <= '0;
    load(4'h3);
    i_kss_ctlr_model.frame(8'h41, 16);
    cyc(10);
    `CHK("reset_held", 1'b1, dev_reset)
    `CHK("gpo_in_reset", GPO_NONE, gpo)
    release_dev();
    `CHK("idle_lines", ALL_LINES, lines)
    `CHK("gpo_after", GPO_ALL, gpo)
  endtask

  task automatic t_modes();
    logic [5:0] msk [4] = '{ALL_LINES, MASK_B_ONLY, MASK_A_ONLY, ALL_LINES};
    logic [3:0] gp [4] = '{GPO_NONE, GPO_B_ONLY, GPO_A_ONLY, GPO_ALL};
    for (int i = 3; i >= 0; i--) begin
      load({2'(i), 2'(i)});
      `CHK("mode_lines", msk[i], lines)
      `CHK("mode_gpo", gp[i], gpo)
      `CHK("mode_ack", i != 0, sleep_ack_bit)
      `CHK("mode_seg", i != 0, seg_com_off)
      `CHK("mode_osc", i == 0, rc_oscillator_pin)
    end
  endtask

  task automatic t_keys();
    keys <= (KEYS'(1) << 13) | (KEYS'(1) << 25);
    wait_req(900);
    `CHK("req_delay", 1'b1, n >= REQ_T && n <= REQ_T + 8)
    i_kss_ctlr_model.frame(8'h41, 8);
    `CHK("do_ce_high", 8'hFF, i_kss_ctlr_model.last[7:0])
    cyc(8);
    `CHK("req_kept", 1'b0, do_line)
    rd({1'b0, 30'h0200_2000});
    `CHK("two_keys_usable", 1'b0, i_kss_ctlr_model.unreliable)
    cyc(10);
    `CHK("req_cleared", 1'b1, do_line)
    `CHK("rescan", 1'b1, lines !== ALL_LINES)
    keys <= '0;
    cyc(1700);
  endtask

  task automatic t_bounce();
    keys <= KEYS'(1) << 29;
    cyc(500);
    keys <= '0;
    wait_req(2000);
    `CHK("short_press", 2000, n)
    keys <= KEYS'(1) << 29;
    cyc(500);
    keys <= KEYS'(1);
    wait_req(1300);
    `CHK("rescan_delay", 1'b1, n + 500 >= 2 * REQ_T && n + 500 <= 2 * REQ_T + 16)
    rd({1'b0, 30'h1});
    keys <= '0;
    cyc(900);
  endtask

  task automatic t_sleep();
    load(4'h4);
    keys <= KEYS'(1);
    wait_req(1000);
    `CHK("low_line_press", 1'b1, do_line)
    `CHK("osc_stopped", 1'b0, rc_oscillator_pin)
    keys <= KEYS'(1) | (KEYS'(1) << 25);
    wait_req(1000);
    `CHK("osc_restart", 1'b1, rc_oscillator_pin)
    rd({1'b1, 30'h0200_0000});
    `CHK("sleep_kept", 1'b1, sleep_ack_bit)
    wait_req(1000);
    load(4'h0);
    `CHK("mode_adopted", 1'b0, sleep_ack_bit)
    rd({1'b1, 30'h0200_0000});
    keys <= '0;
    cyc(900);
  endtask

  task automatic t_drop();
    load(4'h3);
    supply_drop_detector <= 1'b1;
    cyc(5);
    supply_drop_detector <= 1'b0;
    cyc(8);
    `CHK("drop_reset", 1'b1, dev_reset)
    `CHK("drop_kbuf", 31'h0, key_word)
    `CHK("drop_seg_off", 1'b1, seg_com_off)
    release_dev();
    `CHK("ctl_kept", GPO_ALL, gpo)
  endtask

  task automatic end_sim();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    supply_drop_detector = 1'b0;
    ctl_load = 1'b0;
    ctl_in = '0;
    final_transfer = 1'b0;
    keys = '0;
    // Link clock must tick while reset is high so the link side is cleared too
    fork
      i_kss_ctlr_model.frame(8'h41, 8);
      begin
        cyc(2);
        reset <= 1'b0;
      end
    join
    cyc(1);
    t_reset();
    t_modes();
    t_keys();
    t_bounce();
    t_sleep();
    t_drop();
    end_sim();
  end

  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
endmodule

`default_nettype wire
